// file: hdl/sseh_defs.svh
// constants for the service save and exit command handler
`ifndef SSEH_DEFS_SVH
`define SSEH_DEFS_SVH

// received characters that the handler decodes
`define SSEH_CH_CR        8'h0D
`define SSEH_CH_SPACE     8'h20
`define SSEH_CH_COMMA     8'h2C
`define SSEH_CH_SAVE      8'h73
`define SSEH_CH_EXIT      8'h78
`define SSEH_CH_YES       8'h59
`define SSEH_CH_NO        8'h4E
`define SSEH_CH_TGT_N     8'h6E
`define SSEH_CH_TGT_I     8'h69
`define SSEH_CH_TGT_NOW_N 8'h4E
`define SSEH_CH_TGT_NOW_I 8'h49

// error codes reported with an error message
`define SSEH_ERR_NONE     3'h0
`define SSEH_ERR_UNKNOWN  3'h1
`define SSEH_ERR_NPARAM   3'h2
`define SSEH_ERR_INVALID  3'h3
`define SSEH_ERR_WEAR     3'h4
`define SSEH_ERR_SAVE     3'h5

// configuration layout and reset values
`define SSEH_CFG_WIDTH    8
`define SSEH_CFG_WORDS    8
`define SSEH_CFG_TX_IDX   0
`define SSEH_CFG_DEFAULT  8'h00
`define SSEH_CNT_WIDTH    16
`define SSEH_SAVE_LIMIT   1000

// hold time before a confirming exit is carried out
`define SSEH_CLK_HZ       10000000
`define SSEH_HOLD_TIME_MS 3000
`define SSEH_HOLD_CYCLES  ((`SSEH_HOLD_TIME_MS) * ((`SSEH_CLK_HZ) / 1000))

`endif

// file: hdl/sseh_pkg.sv
// types shared by the service save and exit command handler
package sseh_pkg;

  // interpreter states
  typedef enum logic [4:0]
  {
    ST_IDLE,
    ST_DRAIN,
    ST_S_CR,
    ST_S_ANS,
    ST_S_E3,
    ST_S_WR,
    ST_S_DONE,
    ST_S_WARN,
    ST_X_SP,
    ST_X_TGT,
    ST_X_CR,
    ST_X_ANS,
    ST_X_HOLD,
    ST_LOAD,
    ST_GO
  } sseh_state_t;

  // messages sent back to the terminal
  typedef enum logic [2:0]
  {
    MSG_NONE,
    MSG_SAVE_PROMPT,
    MSG_SAVE_OK,
    MSG_SAVE_ABORT,
    MSG_EXIT_PROMPT,
    MSG_RET_NORMAL,
    MSG_RET_INIT,
    MSG_ERROR
  } sseh_msg_t;

endpackage

// file: hdl/sseh_store.sv
// nonvolatile configuration store with registered read data
`timescale 1ns/1ns
module sseh_store
#(
  parameter int             W       = 8,
  parameter int             N       = 8,
  parameter int             AW      = 3,
  parameter logic [W-1:0]   RST_VAL = '0
)(
  input  wire logic          sys_clk, // system clock
  input  wire logic          rst,     // asynchronous reset, high
  input  wire logic          wr_en,   // write one word
  input  wire logic          rd_en,   // read one word
  input  wire logic [AW-1:0] addr,    // word index
  input  wire logic [W-1:0]  wdata,   // write data
  output logic      [W-1:0]  rdata    // read data, one cycle after rd_en
);

  logic [W-1:0] mem_ff [N];
  logic [W-1:0] rdata_ff;

  // storage array, starts from the default image
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int k = 0; k < N; k++)
        mem_ff[k] <= RST_VAL;
    end
    else if (wr_en)
      mem_ff[addr] <= wdata;
  end

  // registered read port
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      rdata_ff <= '0;
    else if (rd_en)
      rdata_ff <= mem_ff[addr];
  end

  assign rdata = rdata_ff;

endmodule

// file: hdl/sseh_service_save_exit.sv
// command interpreter for the service-mode save and exit commands
`timescale 1ns/1ns
`include "sseh_defs.svh"
module sseh_service_save_exit
  import sseh_pkg::*;
#(
  parameter int CFG_W       = `SSEH_CFG_WIDTH,
  parameter int CFG_N       = `SSEH_CFG_WORDS,
  parameter int IDX_W       = $clog2(`SSEH_CFG_WORDS),
  parameter int CNT_W       = `SSEH_CNT_WIDTH,
  parameter int HOLD_CYCLES = `SSEH_HOLD_CYCLES
)(
  input  wire logic                   sys_clk,    // system clock, 10 MHz
  input  wire logic                   rst,        // asynchronous reset, high
  input  wire logic                   rx_valid,   // one received character
  input  wire logic [7:0]             rx_char,    // received character code
  input  wire logic                   cfg_wr_en,  // working setting write
  input  wire logic [IDX_W-1:0]       cfg_wr_idx, // working setting index
  input  wire logic [CFG_W-1:0]       cfg_wr_data,// working setting value
  input  wire logic                   nvm_fault,  // store write did not take
  output logic                        cfg_busy,   // command in progress
  output logic [CFG_N*CFG_W-1:0]      cfg_words,  // working settings
  output logic                        cfg_dirty,  // settings differ from store
  output logic                        msg_valid,  // message pulse
  output sseh_msg_t                   msg_code,   // message kind
  output logic [2:0]                  err_code,   // error number with MSG_ERROR
  output logic [CNT_W-1:0]            save_count, // completed saves
  output logic                        go_normal,  // leave for Normal Mode
  output logic                        go_init     // leave for Init Mode
);

  sseh_state_t      state_ff;
  sseh_state_t      nxt_state;
  logic [2:0]       drain_err_ff;
  logic [2:0]       nxt_drain;
  sseh_msg_t        emit_msg;
  logic [2:0]       emit_err;
  logic [CFG_W-1:0] wcfg_ff [CFG_N];
  logic [IDX_W-1:0] idx_ff;
  logic             phase_ff;
  logic             load_all_ff;
  logic [IDX_W-1:0] ld_end;
  logic             fail_acc_ff;
  logic             dirty_ff;
  logic             tx_chg_ff;
  logic [7:0]       tgt_ff;
  logic [31:0]      hold_cnt_ff;
  logic [CNT_W-1:0] save_count_ff;
  logic             msg_valid_ff;
  sseh_msg_t        msg_code_ff;
  logic [2:0]       err_code_ff;
  logic             go_normal_ff;
  logic             go_init_ff;
  logic             st_wr;
  logic             st_rd;
  logic [CFG_W-1:0] st_rdata;
  logic             rx_cr;
  logic             ld_last;
  logic             save_good;
  localparam logic [IDX_W-1:0] TX_IDX = IDX_W'(`SSEH_CFG_TX_IDX);
  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(CFG_N - 1);

  // true when the exit target heads for Init Mode
  function automatic logic f_is_init(input logic [7:0] t);
    f_is_init = (t == `SSEH_CH_TGT_I) || (t == `SSEH_CH_TGT_NOW_I);
  endfunction

  // notice that names the mode being returned to
  function automatic sseh_msg_t f_note(input logic [7:0] t);
    f_note = f_is_init(t) ? MSG_RET_INIT : MSG_RET_NORMAL;
  endfunction

  assign rx_cr     = rx_valid && (rx_char == `SSEH_CH_CR);
  assign ld_end    = load_all_ff ? LAST_IDX : TX_IDX;
  assign ld_last   = (state_ff == ST_LOAD) && phase_ff && (idx_ff == ld_end);
  assign save_good = (state_ff == ST_S_DONE) && !fail_acc_ff;

  //--------------------------------------------------------------------
  // command decoding
  //--------------------------------------------------------------------

  // next state and message selection
  always_comb
  begin
    nxt_state = state_ff;
    nxt_drain = drain_err_ff;
    emit_msg  = MSG_NONE;
    emit_err  = `SSEH_ERR_NONE;
    case (state_ff)
      ST_IDLE:
        if (rx_valid)
        begin
          if (rx_char == `SSEH_CH_SAVE)
            nxt_state = ST_S_CR;
          else if (rx_char == `SSEH_CH_EXIT)
            nxt_state = ST_X_SP;
          else if (!rx_cr)
          begin
            nxt_state = ST_DRAIN; // another command's line
            nxt_drain = `SSEH_ERR_NONE;
          end
        end
      ST_DRAIN:
        if (rx_cr)
        begin
          nxt_state = ST_IDLE;
          if (drain_err_ff != `SSEH_ERR_NONE)
          begin
            emit_msg = MSG_ERROR;
            emit_err = drain_err_ff;
          end
        end
      ST_S_CR:
        if (rx_cr)
        begin
          emit_msg  = MSG_SAVE_PROMPT;
          nxt_state = ST_S_ANS;
        end
        else if (rx_valid)
        begin
          nxt_state = ST_DRAIN;
          nxt_drain = `SSEH_ERR_NPARAM;
        end
      ST_S_ANS:
        if (rx_valid)
        begin
          if (rx_char == `SSEH_CH_YES)
            nxt_state = ST_S_WR;
          else
          begin
            emit_msg = MSG_SAVE_ABORT;
            if (rx_char != `SSEH_CH_NO)
              nxt_state = ST_S_E3;
            else
              nxt_state = tx_chg_ff ? ST_LOAD : ST_IDLE;
          end
        end
      ST_S_E3:
      begin
        emit_msg  = MSG_ERROR;
        emit_err  = `SSEH_ERR_INVALID;
        nxt_state = tx_chg_ff ? ST_LOAD : ST_IDLE;
      end
      ST_S_WR:
        if (idx_ff == LAST_IDX)
          nxt_state = ST_S_DONE;
      ST_S_DONE:
      begin
        if (fail_acc_ff)
        begin
          emit_msg  = MSG_ERROR;
          emit_err  = `SSEH_ERR_SAVE;
          nxt_state = ST_IDLE;
        end
        else
        begin
          emit_msg  = MSG_SAVE_OK;
          nxt_state = ST_S_WARN;
        end
      end
      ST_S_WARN:
      begin
        nxt_state = ST_IDLE;
        if (save_count_ff > CNT_W'(`SSEH_SAVE_LIMIT))
        begin
          emit_msg = MSG_ERROR;
          emit_err = `SSEH_ERR_WEAR;
        end
      end
      ST_X_SP:
        if (rx_cr)
        begin
          emit_msg  = MSG_ERROR;
          emit_err  = `SSEH_ERR_NPARAM;
          nxt_state = ST_IDLE;
        end
        else if (rx_valid)
        begin
          nxt_state = (rx_char == `SSEH_CH_SPACE) ? ST_X_TGT : ST_DRAIN;
          nxt_drain = (rx_char == `SSEH_CH_COMMA) ? `SSEH_ERR_NPARAM : `SSEH_ERR_UNKNOWN;
        end
      ST_X_TGT:
        if (rx_cr)
        begin
          emit_msg  = MSG_ERROR;
          emit_err  = `SSEH_ERR_NPARAM;
          nxt_state = ST_IDLE;
        end
        else if (rx_valid)
          nxt_state = ST_X_CR;
      ST_X_CR:
        if (rx_cr)
        begin
          case (tgt_ff)
            `SSEH_CH_TGT_N, `SSEH_CH_TGT_I:
            begin
              emit_msg  = dirty_ff ? MSG_EXIT_PROMPT : f_note(tgt_ff);
              nxt_state = dirty_ff ? ST_X_ANS : ST_X_HOLD;
            end
            `SSEH_CH_TGT_NOW_N:
            begin
              emit_msg  = MSG_RET_NORMAL;
              nxt_state = ST_GO;
            end
            `SSEH_CH_TGT_NOW_I:
            begin
              emit_msg  = MSG_RET_INIT;
              nxt_state = ST_LOAD;
            end
            default:
            begin
              emit_msg  = MSG_ERROR;
              emit_err  = `SSEH_ERR_INVALID;
              nxt_state = ST_IDLE;
            end
          endcase
        end
        else if (rx_valid)
        begin
          nxt_state = ST_DRAIN;
          nxt_drain = `SSEH_ERR_NPARAM;
        end
      ST_X_ANS:
        if (rx_valid)
        begin
          nxt_state = ST_IDLE;
          if (rx_char == `SSEH_CH_YES)
          begin
            emit_msg  = f_note(tgt_ff);
            nxt_state = ST_X_HOLD;
          end
          else if (rx_char != `SSEH_CH_NO)
          begin
            emit_msg = MSG_ERROR;
            emit_err = `SSEH_ERR_INVALID;
          end
        end
      ST_X_HOLD:
        if (hold_cnt_ff == 32'(HOLD_CYCLES - 1))
          nxt_state = f_is_init(tgt_ff) ? ST_LOAD : ST_GO;
      ST_LOAD:
        if (ld_last)
          nxt_state = load_all_ff ? ST_GO : ST_IDLE;
      ST_GO:
        nxt_state = ST_IDLE;
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  // state, pending drain error and exit target
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff     <= ST_IDLE;
      drain_err_ff <= `SSEH_ERR_NONE;
      tgt_ff       <= 8'h00;
    end
    else
    begin
      state_ff     <= nxt_state;
      drain_err_ff <= nxt_drain;
      if ((state_ff == ST_X_TGT) && rx_valid && !rx_cr)
        tgt_ff <= rx_char;
    end
  end

  //--------------------------------------------------------------------
  // store transfers
  //--------------------------------------------------------------------

  // word index, load phase and load scope
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      idx_ff      <= '0;
      phase_ff    <= 1'b0;
      load_all_ff <= 1'b0;
    end
    else if ((nxt_state == ST_LOAD) && (state_ff != ST_LOAD))
    begin
      load_all_ff <= (state_ff != ST_S_ANS) && (state_ff != ST_S_E3);
      idx_ff      <= ((state_ff != ST_S_ANS) && (state_ff != ST_S_E3)) ? '0 : TX_IDX;
      phase_ff    <= 1'b0;
    end
    else if ((nxt_state == ST_S_WR) && (state_ff != ST_S_WR))
      idx_ff <= '0;
    else if (state_ff == ST_S_WR)
      idx_ff <= idx_ff + 1'b1;
    else if (state_ff == ST_LOAD)
    begin
      phase_ff <= !phase_ff;
      if (phase_ff && !ld_last)
        idx_ff <= idx_ff + 1'b1;
    end
  end

  // write every word whatever the count
  assign st_wr = (state_ff == ST_S_WR);
  assign st_rd = (state_ff == ST_LOAD) && !phase_ff;

  sseh_store
  #(
    .W       (CFG_W),
    .N       (CFG_N),
    .AW      (IDX_W),
    .RST_VAL (`SSEH_CFG_DEFAULT)
  ) u_store (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wr_en   (st_wr),
    .rd_en   (st_rd),
    .addr    (idx_ff),
    .wdata   (wcfg_ff[idx_ff]),
    .rdata   (st_rdata)
  );

  // failure seen on any word of the write
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      fail_acc_ff <= 1'b0;
    else if (state_ff == ST_S_ANS)
      fail_acc_ff <= 1'b0;
    else if (st_wr)
      fail_acc_ff <= fail_acc_ff | nvm_fault;
  end

  //--------------------------------------------------------------------
  // working settings
  //--------------------------------------------------------------------

  // volatile working copy, reloaded or written
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int k = 0; k < CFG_N; k++)
        wcfg_ff[k] <= `SSEH_CFG_DEFAULT;
    end
    else if ((state_ff == ST_LOAD) && phase_ff)
      wcfg_ff[idx_ff] <= st_rdata;
    else if (cfg_wr_en && (state_ff == ST_IDLE))
      wcfg_ff[cfg_wr_idx] <= cfg_wr_data;
  end

  // differs-from-store and transmission-changed flags, set wins
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      dirty_ff  <= 1'b0;
      tx_chg_ff <= 1'b0;
    end
    else if (cfg_wr_en && (state_ff == ST_IDLE))
    begin
      dirty_ff  <= 1'b1;
      tx_chg_ff <= tx_chg_ff | (cfg_wr_idx == TX_IDX);
    end
    else if (save_good || (ld_last && load_all_ff))
    begin
      dirty_ff  <= 1'b0;
      tx_chg_ff <= 1'b0;
    end
    else if (ld_last)
      tx_chg_ff <= 1'b0;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      save_count_ff <= '0;
    else if (save_good)
      save_count_ff <= save_count_ff + 1'b1;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      hold_cnt_ff <= 32'h00000000;
    else if (state_ff == ST_X_HOLD)
      hold_cnt_ff <= hold_cnt_ff + 32'h00000001;
    else
      hold_cnt_ff <= 32'h00000000;
  end

  //--------------------------------------------------------------------
  // outputs
  //--------------------------------------------------------------------

  // registered message and mode change pulses
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      msg_valid_ff <= 1'b0;
      msg_code_ff  <= MSG_NONE;
      err_code_ff  <= `SSEH_ERR_NONE;
      go_normal_ff <= 1'b0;
      go_init_ff   <= 1'b0;
    end
    else
    begin
      msg_valid_ff <= (emit_msg != MSG_NONE);
      msg_code_ff  <= emit_msg;
      err_code_ff  <= emit_err;
      go_normal_ff <= (state_ff == ST_GO) && !f_is_init(tgt_ff);
      go_init_ff   <= (state_ff == ST_GO) && f_is_init(tgt_ff);
    end
  end

  assign cfg_busy   = (state_ff != ST_IDLE);
  assign cfg_dirty  = dirty_ff;
  assign msg_valid  = msg_valid_ff;
  assign msg_code   = msg_code_ff;
  assign err_code   = err_code_ff;
  assign save_count = save_count_ff;
  assign go_normal  = go_normal_ff;
  assign go_init    = go_init_ff;

  // flattened working settings, word 0 lowest
  always_comb
  begin
    cfg_words = '0;
    for (int k = 0; k < CFG_N; k++)
      cfg_words[k*CFG_W +: CFG_W] = wcfg_ff[k];
  end

  //--------------------------------------------------------------------
  // checks
  //--------------------------------------------------------------------

  property p_save_prompt;
    @(posedge sys_clk) disable iff (rst)
    (state_ff == ST_S_CR) && rx_cr |=> msg_valid && (msg_code == MSG_SAVE_PROMPT);
  endproperty
  a_save_prompt: assert property (p_save_prompt) else $error("no save prompt");

  property p_save_nparam;
    @(posedge sys_clk) disable iff (rst)
    (state_ff == ST_S_CR) && rx_valid && !rx_cr
      |=> (state_ff == ST_DRAIN) && (drain_err_ff == `SSEH_ERR_NPARAM);
  endproperty
  a_save_nparam: assert property (p_save_nparam) else $error("extra chars not refused");

  property p_save_go;
    @(posedge sys_clk) disable iff (rst)
    (state_ff == ST_S_ANS) && rx_valid && (rx_char == `SSEH_CH_YES)
      |=> st_wr [*8] ##1 (state_ff == ST_S_DONE);
  endproperty
  a_save_go: assert property (p_save_go) else $error("save not attempted");

  property p_bad_answer;
    @(posedge sys_clk) disable iff (rst)
    (state_ff == ST_S_ANS) && rx_valid && (rx_char != `SSEH_CH_YES)
      && (rx_char != `SSEH_CH_NO)
      |=> (msg_code == MSG_SAVE_ABORT) ##1 (err_code == `SSEH_ERR_INVALID);
  endproperty
  a_bad_answer: assert property (p_bad_answer) else $error("bad answer not reported");

  property p_tx_restore;
    @(posedge sys_clk) disable iff (rst)
    (state_ff == ST_S_ANS) && rx_valid && (rx_char == `SSEH_CH_NO) && tx_chg_ff
      |=> (state_ff == ST_LOAD) && !load_all_ff ##[1:3] !tx_chg_ff;
  endproperty
  a_tx_restore: assert property (p_tx_restore) else $error("tx settings kept");

  property p_save_fail;
    @(posedge sys_clk) disable iff (rst)
    (state_ff == ST_S_DONE) && fail_acc_ff
      |=> msg_valid && (err_code == `SSEH_ERR_SAVE) && $stable(save_count_ff);
  endproperty
  a_save_fail: assert property (p_save_fail) else $error("save failure missed");

  property p_wear;
    @(posedge sys_clk) disable iff (rst)
    (msg_code == MSG_SAVE_OK) && (save_count_ff > CNT_W'(`SSEH_SAVE_LIMIT))
      |=> (msg_code == MSG_ERROR) && (err_code == `SSEH_ERR_WEAR);
  endproperty
  a_wear: assert property (p_wear) else $error("wear warning missing");

  property p_save_ok;
    @(posedge sys_clk) disable iff (rst)
    save_good |=> (msg_code == MSG_SAVE_OK) && (save_count_ff == $past(save_count_ff) + 1'b1);
  endproperty
  a_save_ok: assert property (p_save_ok) else $error("save count not reported");

  property p_hold_wait;
    @(posedge sys_clk) disable iff (rst)
    (state_ff == ST_X_HOLD) && (hold_cnt_ff < 32'(HOLD_CYCLES - 1)) |=> (state_ff == ST_X_HOLD);
  endproperty
  a_hold_wait: assert property (p_hold_wait) else $error("hold cut short");

  property p_exit_now;
    @(posedge sys_clk) disable iff (rst)
    (state_ff == ST_X_CR) && rx_cr && (tgt_ff == `SSEH_CH_TGT_NOW_N)
      |=> (msg_code == MSG_RET_NORMAL) ##1 go_normal;
  endproperty
  a_exit_now: assert property (p_exit_now) else $error("direct exit delayed");

  property p_exit_bad_answer;
    @(posedge sys_clk) disable iff (rst)
    (state_ff == ST_X_ANS) && rx_valid && (rx_char == `SSEH_CH_TGT_N)
      |=> (err_code == `SSEH_ERR_INVALID) && (state_ff == ST_IDLE) ##1 !go_normal;
  endproperty
  a_exit_bad_answer: assert property (p_exit_bad_answer) else $error("bad exit answer");

  property p_init_clean;
    @(posedge sys_clk) disable iff (rst)
    go_init |-> !dirty_ff && !tx_chg_ff;
  endproperty
  a_init_clean: assert property (p_init_clean) else $error("init with unsaved settings");

endmodule

// file: bench/sseh_host.sv
// host terminal model driving the character link
`timescale 1ns/1ns
module sseh_host
(
  input  wire logic       sys_clk,  // system clock
  output logic            rx_valid, // character strobe
  output logic [7:0]      rx_char   // character code
);
  // idle link at power up
  initial
  begin
    rx_valid = 1'b0;
    rx_char  = 8'h00;
  end
  task automatic send(input string s);
    foreach (s[i])
    begin
      @(posedge sys_clk);
      #1;
      rx_valid = 1'b1;
      rx_char  = s[i];
    end
    @(posedge sys_clk);
    #1;
    rx_valid = 1'b0;
    rx_char  = ~rx_char; // stale code must not look valid
  endtask
endmodule

// file: bench/tb.sv
// self-checking bench for the service save and exit handler
`timescale 1ns/1ns
`include "sseh_defs.svh"
module tb
  import sseh_pkg::*;
;
  localparam int HOLD = 40;
  logic        sys_clk, rst, rx_valid, cfg_wr_en, nvm_fault, cfg_busy, cfg_dirty;
  logic        msg_valid, go_normal, go_init;
  logic [7:0]  rx_char, cfg_wr_data;
  logic [2:0]  cfg_wr_idx, err_code;
  logic [63:0] cfg_words;
  logic [15:0] save_count;
  sseh_msg_t   msg_code;
  logic [7:0]  evq[$];
  int          tq[$];
  int          cyc = 0, err_total = 0, checks_done = 0, t0, t1;

  sseh_service_save_exit #(.HOLD_CYCLES(HOLD)) u_dut (.sys_clk, .rst, .rx_valid, .rx_char,
    .cfg_wr_en, .cfg_wr_idx, .cfg_wr_data, .nvm_fault, .cfg_busy, .cfg_words, .cfg_dirty,
    .msg_valid, .msg_code, .err_code, .save_count, .go_normal, .go_init);
  sseh_host u_host (.sys_clk, .rx_valid, .rx_char);

  // clock source
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // record messages and leave pulses with their cycle, cut hangs short
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (msg_valid | go_normal | go_init)
    begin
      evq.push_back({go_init, go_normal, err_code, msg_code});
      tq.push_back(cyc);
    end
    if (cyc == 60000)
    begin
      err_total++;
      final_report();
    end
  end

  function automatic logic [7:0] m(input sseh_msg_t c, input logic [2:0] e);
    return {2'b00, e, c};
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  // compare the next recorded event, waiting a bounded time
  task automatic ev(input logic [7:0] e);
    logic [7:0] g;
    g = 8'hXX;
    for (int i = 0; i < 200 && evq.size() == 0; i++)
      @(posedge sys_clk);
    if (evq.size() != 0)
    begin
      g  = evq.pop_front();
      t1 = tq.pop_front();
    end
    chk("event", {8'h00, e}, {8'h00, g});
  endtask
  task automatic idle();
    for (int i = 0; i < 200 && cfg_busy !== 1'b0; i++)
      @(posedge sys_clk);
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [2:0] i, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    cfg_wr_en   = 1'b1;
    cfg_wr_idx  = i;
    cfg_wr_data = d;
    @(posedge sys_clk);
    #1;
    cfg_wr_en = 1'b0;
  endtask
  task automatic save(input string a);
    u_host.send("s\r");
    ev(m(MSG_SAVE_PROMPT, 3'h0));
    u_host.send(a);
  endtask
  task automatic go(input string s, input sseh_msg_t c, input logic [7:0] p);
    u_host.send(s);
    ev(m(c, 3'h0));
    t0 = t1;
    ev(p);
  endtask

  task automatic t_save();
    wr(3'h0, 8'h5A);
    wr(3'h3, 8'h33);
    save("Y");
    ev(m(MSG_SAVE_OK, 3'h0));
    idle();
    chk("count", 16'h0001, save_count);
    chk("dirty", 16'h0000, {15'h0000, cfg_dirty});
    $display("save test done");
  endtask
  task automatic t_abort();
    wr(3'h0, 8'hA5);
    save("N");
    ev(m(MSG_SAVE_ABORT, 3'h0));
    idle();
    chk("word0", 16'h005A, {8'h00, cfg_words[7:0]});
    wr(3'h0, 8'hA5);
    save("y");
    ev(m(MSG_SAVE_ABORT, 3'h0));
    ev(m(MSG_ERROR, `SSEH_ERR_INVALID));
    idle();
    chk("word0", 16'h005A, {8'h00, cfg_words[7:0]});
    $display("abort test done");
  endtask
  task automatic t_errs();
    u_host.send("sq\r");
    ev(m(MSG_ERROR, `SSEH_ERR_NPARAM));
    idle();
    nvm_fault = 1'b1;
    save("Y");
    ev(m(MSG_ERROR, `SSEH_ERR_SAVE));
    idle();
    nvm_fault = 1'b0;
    chk("count", 16'h0001, save_count);
    u_host.send("xq\r");
    ev(m(MSG_ERROR, `SSEH_ERR_UNKNOWN));
    u_host.send("x\r");
    ev(m(MSG_ERROR, `SSEH_ERR_NPARAM));
    u_host.send("x z\r");
    ev(m(MSG_ERROR, `SSEH_ERR_INVALID));
    u_host.send("q\r");
    u_host.send("x,n\r");
    ev(m(MSG_ERROR, `SSEH_ERR_NPARAM));
    u_host.send("x n?\r");
    ev(m(MSG_ERROR, `SSEH_ERR_NPARAM));
    idle();
    $display("error test done");
  endtask
  task automatic t_exit();
    wr(3'h1, 8'h11);
    u_host.send("x n\r");
    ev(m(MSG_EXIT_PROMPT, 3'h0));
    u_host.send("n");
    ev(m(MSG_ERROR, `SSEH_ERR_INVALID));
    idle();
    u_host.send("x n\r");
    ev(m(MSG_EXIT_PROMPT, 3'h0));
    u_host.send("N");
    idle();
    u_host.send("x i\r");
    ev(m(MSG_EXIT_PROMPT, 3'h0));
    go("Y", MSG_RET_INIT, 8'h80);
    chk("hold", 16'h0001, {15'h0000, t1 - t0 >= HOLD});
    idle();
    chk("words", 16'h005A, cfg_words[15:0]);
    go("x n\r", MSG_RET_NORMAL, 8'h40);
    chk("hold", 16'h0001, {15'h0000, t1 - t0 >= HOLD});
    idle();
    wr(3'h2, 8'h22);
    go("x N\r", MSG_RET_NORMAL, 8'h40);
    chk("nohold", 16'h0001, {15'h0000, t1 - t0 == 1});
    idle();
    go("x I\r", MSG_RET_INIT, 8'h80);
    chk("nohold", 16'h0001, {15'h0000, t1 - t0 < HOLD});
    idle();
    chk("word2", 16'h0000, {8'h00, cfg_words[23:16]});
    $display("exit test done");
  endtask
  task automatic t_wear();
    for (int k = 1; k < 1000; k++)
    begin
      save("Y");
      ev(m(MSG_SAVE_OK, 3'h0));
      idle();
    end
    chk("spare", 16'h0000, 16'(evq.size()));
    save("Y");
    ev(m(MSG_SAVE_OK, 3'h0));
    ev(m(MSG_ERROR, `SSEH_ERR_WEAR));
    idle();
    chk("count", 16'h03E9, save_count);
    $display("wear test done");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // reset, then the scenarios in turn
  initial
  begin
    rst         = 1'b1;
    cfg_wr_en   = 1'b0;
    cfg_wr_idx  = 3'h0;
    cfg_wr_data = 8'h00;
    nvm_fault   = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    t_save();
    t_abort();
    t_errs();
    t_exit();
    t_wear();
    final_report();
  end
endmodule
